// ===== rtl/qls_serializer.sv
// Output serializer of a four-channel 12-bit converter with bit and frame clocks.
`timescale 1ns/100ps
`default_nettype none

module qls_serializer
    import qls_pkg::*;
#(
    parameter int CONV_LATENCY = `QLS_CONV_LATENCY
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire qls_sample_t [`QLS_CHANNELS-1:0] sample_in,
    input wire logic two_wire_en,
    input wire logic ser14_en,
    input wire logic sdr_bit_clk,
    input wire qls_order_t bit_order,
    input wire logic lsb_first,
    input wire logic output_code_format,
    input wire qls_pattern_t test_pattern,
    input wire logic deskew_phase,
    input wire logic [`QLS_SAMPLE_BITS-1:0] custom_word,
    input wire logic [1:0] drive_current_select,
    input wire logic drive_current_x2,
    input wire logic [4:0] term_clk_sel,
    input wire logic [4:0] term_data_sel,
    output logic chan_a_first_pair,
    output logic chan_a_second_pair,
    output logic chan_b_first_pair,
    output logic chan_b_second_pair,
    output logic chan_c_first_pair,
    output logic chan_c_second_pair,
    output logic chan_d_first_pair,
    output logic chan_d_second_pair,
    output logic frame_clock_out,
    output logic serial_bit_clock_out,
    output logic [1:0] drive_current_code,
    output logic drive_current_double,
    output logic [4:0] term_clk_legs,
    output logic [4:0] term_data_legs
);

    ////////////////////////////////////////////////////////////////////////////
    // Bit selection helpers for the link side and coding helpers for the sampling side; two_per_frame serves both.

    function automatic logic [4:0] bits_per_word(qls_cfg_t c);
        if (!c.two_wire || c.order == QLS_ORD_WORD) begin
            return c.ser14 ? `QLS_BITS_1W_14X : `QLS_BITS_1W_12X;
        end
        return c.ser14 ? `QLS_BITS_2W_14X : `QLS_BITS_2W_12X;
    endfunction : bits_per_word

    function automatic logic [4:0] sync_ones(logic [4:0] nb);
        case (nb)
            `QLS_BITS_1W_14X: return `QLS_SYNC_ONES_14;
            `QLS_BITS_2W_12X: return `QLS_SYNC_ONES_6;
            `QLS_BITS_2W_14X: return `QLS_SYNC_ONES_7;
            default: return `QLS_SYNC_ONES_12;
        endcase
    endfunction : sync_ones

    // Two samples share a frame when the frame clock runs at half rate.
    function automatic logic two_per_frame(qls_cfg_t c);
        return c.two_wire && c.ser14 && !c.sdr && c.order != QLS_ORD_WORD;
    endfunction : two_per_frame

    function automatic logic [4:0] frame_len(qls_cfg_t c);
        logic [4:0] len;
        len = bits_per_word(c);
        if (two_per_frame(c)) begin
            len = 5'(len << 1);
        end
        if (c.sdr) begin
            len = 5'(len << 1);
        end
        return len;
    endfunction : frame_len

    // One word's share on one pair, left aligned, first bit on top.
    function automatic qls_word_t pair_field(qls_word_t w, logic pair, qls_cfg_t c);
        logic [4:0] nb;
        int kk;
        int j;
        qls_word_t f;
        nb = bits_per_word(c);
        f = '0;
        for (int k = 0; k < `QLS_WORD_BITS; k++) begin
            if (k < int'(nb)) begin
                kk = c.lsb_first ? int'(nb) - 1 - k : k;
                if (c.two_wire && c.order == QLS_ORD_BYTE) begin
                    j = int'(pair) * int'(nb) + int'(nb) - 1 - kk;
                end else if (c.two_wire && c.order == QLS_ORD_BIT) begin
                    j = 2 * (int'(nb) - 1 - kk) + int'(pair);
                end else begin
                    j = int'(nb) - 1 - kk;
                end
                if (c.sync) begin
                    f[`QLS_WORD_BITS-1-k] = (kk < int'(sync_ones(nb)));
                end else begin
                    f[`QLS_WORD_BITS-1-k] = w[j];
                end
            end
        end
        return f;
    endfunction : pair_field

    function automatic qls_word_t pair_frame(qls_frame_src_t s, int ch, logic pair);
        qls_word_t f0;
        qls_word_t f1;
        f0 = '0;
        if (!s.cfg.two_wire) begin
            f0 = pair ? '0 : pair_field(s.w0[ch], 1'b0, s.cfg);
        end else if (s.cfg.order == QLS_ORD_WORD) begin
            f0 = pair_field(pair ? s.w1[ch] : s.w0[ch], 1'b0, s.cfg);
        end else if (two_per_frame(s.cfg)) begin
            f1 = pair_field(s.w1[ch], pair, s.cfg);
            f0 = pair_field(s.w0[ch], pair, s.cfg) | (f1 >> bits_per_word(s.cfg));
        end else begin
            f0 = pair_field(s.w0[ch], pair, s.cfg);
        end
        return f0;
    endfunction : pair_frame

    // Code the delayed sample or substitute the chosen capture pattern.
    function automatic logic [11:0] sample_code(qls_sample_t s, logic fmt, qls_pattern_t pat,
                                                logic tog, logic dsk, logic [11:0] cust);
        logic [11:0] v;
        v = s.code;
        if (s.ovr_pos) begin
            v = `QLS_TWOS_POS_FS;
        end else if (s.ovr_neg) begin
            v = `QLS_TWOS_NEG_FS;
        end
        if (fmt) begin
            v = v ^ `QLS_OB_FLIP;
        end
        case (pat)
            QLS_PAT_ZEROS: v = `QLS_ALL_ZEROS;
            QLS_PAT_ONES: v = `QLS_ALL_ONES;
            QLS_PAT_TOGGLE: v = tog ? `QLS_PAT_0101 : `QLS_PAT_1010;
            QLS_PAT_CUSTOM: v = cust;
            QLS_PAT_DESKEW: v = dsk ? `QLS_PAT_0101 : `QLS_PAT_1010;
            default: v = v;
        endcase
        return v;
    endfunction : sample_code

    ////////////////////////////////////////////////////////////////////////////
    // Conversion latency line on the sampling clock.

    qls_sample_t [`QLS_CHANNELS-1:0] dly_q [CONV_LATENCY];

    always_ff @(posedge core_clk) begin
        dly_q[0] <= sample_in;
        for (int i = 1; i < CONV_LATENCY; i++) begin
            dly_q[i] <= dly_q[i-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampling clock side: coding, sample pairing and the hand-off mailbox.

    qls_core_st_t core_q;
    qls_core_st_t core_d;
    qls_link_st_t link_q;
    qls_link_st_t link_d;
    qls_cfg_t cur_cfg;
    qls_word_t [`QLS_CHANNELS-1:0] words;
    logic need_two;
    logic ld;

    always_comb begin
        core_d = core_q;
        cur_cfg.two_wire = two_wire_en;
        cur_cfg.ser14 = ser14_en;
        cur_cfg.sdr = sdr_bit_clk & two_wire_en;
        cur_cfg.order = bit_order;
        cur_cfg.lsb_first = lsb_first;
        cur_cfg.sync = (test_pattern == QLS_PAT_SYNC);
        // All four channels see the same pattern in the same sample.
        for (int ch = 0; ch < `QLS_CHANNELS; ch++) begin
            words[ch] = {2'h0, sample_code(dly_q[CONV_LATENCY-1][ch], output_code_format,
                test_pattern, core_q.tog, deskew_phase, custom_word)};
        end
        need_two = two_wire_en && (bit_order == QLS_ORD_WORD || two_per_frame(cur_cfg));
        core_d.ack_s1 = link_q.ack;
        core_d.ack_s2 = core_q.ack_s1;
        core_d.tog = ~core_q.tog;
        // The mailbox only changes once the link has taken the previous one,
        // so the link can sample it as a whole without tearing.
        if (core_q.stage_new && core_q.ack_s2 == core_q.req) begin
            core_d.mbox = core_q.stage;
            core_d.req = ~core_q.req;
            core_d.stage_new = 1'b0;
        end
        if (need_two && !core_q.phase) begin
            core_d.held = words;
            core_d.phase = 1'b1;
        end else begin
            core_d.stage.cfg = cur_cfg;
            core_d.stage.w0 = need_two ? core_q.held : words;
            core_d.stage.w1 = words;
            core_d.stage_new = 1'b1;
            core_d.phase = 1'b0;
        end
        core_d.curr = drive_current_select;
        core_d.curr_x2 = drive_current_x2;
        core_d.term_clk = term_clk_sel;
        core_d.term_data = term_data_sel;
        if (!rst_n) begin
            core_d = '0;
            core_d.curr = `QLS_CURR_3P5MA;
            core_d.term_clk = `QLS_TERM_NONE;
            core_d.term_data = `QLS_TERM_NONE;
        end
    end

    always_ff @(posedge core_clk) begin
        core_q <= core_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link clock side: one bit slot per link clock cycle.

    always_comb begin
        link_d = link_q;
        link_d.rst_s1 = rst_n;
        link_d.rst_s2 = link_q.rst_s1;
        link_d.req_s1 = core_q.req;
        link_d.req_s2 = link_q.req_s1;
        link_d.req_s3 = link_q.req_s2;
        if (link_q.req_s2 != link_q.req_s3) begin
            link_d.cap = core_q.mbox;
            link_d.cap_valid = 1'b1;
            link_d.ack = link_q.req_s2;
        end
        ld = (link_q.state == QLS_LNK_RUN && link_q.slot == 5'(link_q.flen - 5'h01)) ||
             (link_q.state == QLS_LNK_IDLE && link_q.cap_valid);
        case (link_q.state)
            QLS_LNK_IDLE, QLS_LNK_RUN: begin
                if (ld) begin
                    // A new word and both clocks start on the same slot.
                    link_d.state = QLS_LNK_RUN;
                    link_d.fcfg = link_q.cap.cfg;
                    link_d.flen = frame_len(link_q.cap.cfg);
                    link_d.slot = '0;
                    link_d.fclk = 1'b1;
                    link_d.bclk = 1'b1;
                    for (int ch = 0; ch < `QLS_CHANNELS; ch++) begin
                        link_d.shift[2*ch] = pair_frame(link_q.cap, ch, 1'b0);
                        link_d.shift[2*ch+1] = pair_frame(link_q.cap, ch, 1'b1);
                    end
                end else if (link_q.state == QLS_LNK_RUN) begin
                    link_d.slot = 5'(link_q.slot + 5'h01);
                    link_d.bclk = ~link_q.bclk;
                    link_d.fclk = (6'(link_q.slot) + 6'h01) * 6'h02 < 6'(link_q.flen);
                    // SDR holds each bit for a full bit clock period.
                    if (!link_q.fcfg.sdr || link_q.slot[0]) begin
                        for (int p = 0; p < 2 * `QLS_CHANNELS; p++) begin
                            link_d.shift[p] = link_q.shift[p] << 1;
                        end
                    end
                end
            end
            default: link_d.state = QLS_LNK_IDLE;
        endcase
        if (!link_q.rst_s2) begin
            link_d = '0;
            link_d.state = QLS_LNK_IDLE;
            link_d.rst_s1 = rst_n;
            link_d.rst_s2 = link_q.rst_s1;
        end
    end

    always_ff @(posedge link_clk) begin
        link_q <= link_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each a flip-flop bit.

    assign chan_a_first_pair = link_q.shift[0][`QLS_WORD_BITS-1];
    assign chan_a_second_pair = link_q.shift[1][`QLS_WORD_BITS-1];
    assign chan_b_first_pair = link_q.shift[2][`QLS_WORD_BITS-1];
    assign chan_b_second_pair = link_q.shift[3][`QLS_WORD_BITS-1];
    assign chan_c_first_pair = link_q.shift[4][`QLS_WORD_BITS-1];
    assign chan_c_second_pair = link_q.shift[5][`QLS_WORD_BITS-1];
    assign chan_d_first_pair = link_q.shift[6][`QLS_WORD_BITS-1];
    assign chan_d_second_pair = link_q.shift[7][`QLS_WORD_BITS-1];
    assign frame_clock_out = link_q.fclk;
    assign serial_bit_clock_out = link_q.bclk;
    assign drive_current_code = core_q.curr;
    assign drive_current_double = core_q.curr_x2;
    assign term_clk_legs = core_q.term_clk;
    assign term_data_legs = core_q.term_data;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    // Slots since the last frame start, so long frames are checked by a count
    // instead of a long repetition that the tools would unroll.
    logic [4:0] since_ld_q;

    always_ff @(posedge link_clk) begin
        since_ld_q <= ld ? 5'h00 : 5'(since_ld_q + 5'h01);
    end

    sequence six_ones_s;
        link_q.shift[0][`QLS_WORD_BITS-1] [*6];
    endsequence

    sequence six_zeros_s;
        !link_q.shift[0][`QLS_WORD_BITS-1] [*6];
    endsequence

    clamp_pos_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (test_pattern == QLS_PAT_NORMAL && dly_q[CONV_LATENCY-1][0].ovr_pos) |->
        words[0][11:0] == (output_code_format ? `QLS_OB_POS_FS : `QLS_TWOS_POS_FS))
        else $error("positive overrange code wrong");

    clamp_neg_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (test_pattern == QLS_PAT_NORMAL && !dly_q[CONV_LATENCY-1][0].ovr_pos &&
         dly_q[CONV_LATENCY-1][0].ovr_neg) |->
        words[0][11:0] == (output_code_format ? `QLS_OB_NEG_FS : `QLS_TWOS_NEG_FS))
        else $error("negative overrange code wrong");

    offset_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (test_pattern == QLS_PAT_NORMAL && output_code_format &&
         !dly_q[CONV_LATENCY-1][1].ovr_pos && !dly_q[CONV_LATENCY-1][1].ovr_neg) |->
        words[1][11:0] == (dly_q[CONV_LATENCY-1][1].code ^ `QLS_OB_FLIP))
        else $error("offset binary code wrong");

    toggle_alt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (test_pattern == QLS_PAT_TOGGLE && $past(test_pattern) == QLS_PAT_TOGGLE) |->
        words[2][11:0] == ~$past(words[2][11:0]) && words[2][13:12] == 2'h0)
        else $error("toggle pattern did not alternate");

    frame_start_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        ld |=> link_q.fclk && link_q.bclk && link_q.slot == '0)
        else $error("frame start not aligned with clocks");

    frame_len12_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        (ld && !link_q.cap.cfg.two_wire && !link_q.cap.cfg.ser14) |->
        ##12 (ld && since_ld_q == 5'h0B))
        else $error("single wire 12x frame length wrong");

    frame_len6_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        (ld && link_q.cap.cfg.two_wire && !link_q.cap.cfg.ser14 && !link_q.cap.cfg.sdr &&
         link_q.cap.cfg.order != QLS_ORD_WORD) |=> (!ld) [*5] ##1 ld)
        else $error("two wire 12x frame length wrong");

    msb_first_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        (ld && !link_q.cap.cfg.two_wire && !link_q.cap.cfg.ser14 &&
         !link_q.cap.cfg.lsb_first && !link_q.cap.cfg.sync) |=>
        chan_a_first_pair == $past(link_q.cap.w0[0][11]))
        else $error("first bit is not the MSB");

    lsb_first_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        (ld && link_q.cap.cfg.two_wire && !link_q.cap.cfg.ser14 && !link_q.cap.cfg.sync &&
         link_q.cap.cfg.lsb_first && link_q.cap.cfg.order == QLS_ORD_BYTE) |=>
        chan_a_first_pair == $past(link_q.cap.w0[0][0]) &&
        chan_a_second_pair == $past(link_q.cap.w0[0][6]))
        else $error("LSB first order per pair wrong");

    sync_word_a: assert property (@(posedge link_clk) disable iff (!link_q.rst_s2)
        (ld && link_q.cap.cfg.sync && !link_q.cap.cfg.two_wire && !link_q.cap.cfg.ser14) |=>
        six_ones_s ##1 six_zeros_s)
        else $error("sync word wrong");

endmodule : qls_serializer

`default_nettype wire

// ===== rtl/qls_params.svh
// Constants of the quad converter serializer: codes, patterns, widths and counts.
`ifndef QLS_PARAMS_SVH
`define QLS_PARAMS_SVH

`define QLS_CHANNELS 4
`define QLS_SAMPLE_BITS 12
`define QLS_WORD_BITS 14
`define QLS_SLOT_BITS 5
`define QLS_CONV_LATENCY 12

`define QLS_BITS_1W_12X 5'h0C
`define QLS_BITS_1W_14X 5'h0E
`define QLS_BITS_2W_12X 5'h06
`define QLS_BITS_2W_14X 5'h07
`define QLS_SYNC_ONES_12 5'h06
`define QLS_SYNC_ONES_14 5'h06
`define QLS_SYNC_ONES_6 5'h03
`define QLS_SYNC_ONES_7 5'h04

`define QLS_TWOS_POS_FS 12'h7FF
`define QLS_TWOS_NEG_FS 12'h800
`define QLS_OB_POS_FS 12'hFFF
`define QLS_OB_NEG_FS 12'h000
`define QLS_OB_FLIP 12'h800
`define QLS_ALL_ZEROS 12'h000
`define QLS_ALL_ONES 12'hFFF
`define QLS_PAT_1010 12'hAAA
`define QLS_PAT_0101 12'h555

`define QLS_CURR_3P5MA 2'h0
`define QLS_CURR_2P5MA 2'h1
`define QLS_CURR_3P0MA 2'h2
`define QLS_CURR_4P5MA 2'h3
`define QLS_TERM_NONE 5'h00

`endif

// ===== rtl/qls_pkg.sv
// Types shared by the quad converter serializer.
package qls_pkg;
`include "qls_params.svh"

    typedef enum logic [6:0] {
        QLS_PAT_NORMAL = 7'h01,
        QLS_PAT_ZEROS = 7'h02,
        QLS_PAT_ONES = 7'h04,
        QLS_PAT_TOGGLE = 7'h08,
        QLS_PAT_CUSTOM = 7'h10,
        QLS_PAT_SYNC = 7'h20,
        QLS_PAT_DESKEW = 7'h40
    } qls_pattern_t;

    typedef enum logic [1:0] {
        QLS_ORD_BYTE = 2'h0,
        QLS_ORD_BIT = 2'h1,
        QLS_ORD_WORD = 2'h2
    } qls_order_t;

    typedef enum logic [1:0] {
        QLS_LNK_IDLE = 2'h1,
        QLS_LNK_RUN = 2'h2
    } qls_link_state_t;

    typedef logic [`QLS_WORD_BITS-1:0] qls_word_t;

    typedef struct packed {
        logic ovr_pos;
        logic ovr_neg;
        logic [`QLS_SAMPLE_BITS-1:0] code;
    } qls_sample_t;

    typedef struct packed {
        logic two_wire;
        logic ser14;
        logic sdr;
        qls_order_t order;
        logic lsb_first;
        logic sync;
    } qls_cfg_t;

    typedef struct packed {
        qls_cfg_t cfg;
        qls_word_t [`QLS_CHANNELS-1:0] w0;
        qls_word_t [`QLS_CHANNELS-1:0] w1;
    } qls_frame_src_t;

    typedef struct packed {
        logic tog;
        logic phase;
        qls_word_t [`QLS_CHANNELS-1:0] held;
        qls_frame_src_t stage;
        logic stage_new;
        qls_frame_src_t mbox;
        logic req;
        logic ack_s1;
        logic ack_s2;
        logic [1:0] curr;
        logic curr_x2;
        logic [4:0] term_clk;
        logic [4:0] term_data;
    } qls_core_st_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack;
        qls_frame_src_t cap;
        logic cap_valid;
        qls_cfg_t fcfg;
        qls_link_state_t state;
        logic [`QLS_SLOT_BITS-1:0] slot;
        logic [`QLS_SLOT_BITS-1:0] flen;
        qls_word_t [2*`QLS_CHANNELS-1:0] shift;
        logic fclk;
        logic bclk;
    } qls_link_st_t;

endpackage : qls_pkg

// ===== tb/qls_rx_model.sv
// Receiver capture model: deserializes every pair, aligned on the frame clock.
`timescale 1ns/100ps
`default_nettype none
module qls_rx_model (
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic fclk,
    input wire logic [7:0] pairs,
    output logic [3:0][13:0] w0,
    output logic [3:0][13:0] w1,
    output logic [4:0] flen
);
    logic [7:0][13:0] sh;
    logic fclk_q;
    logic [4:0] cnt;
    // Sampling mid-slot keeps the capture clear of the launch edge.
    always @(negedge link_clk) begin
        fclk_q <= fclk;
        if (!rst_n) begin
            sh <= '0;
            cnt <= 5'h00;
            flen <= 5'h00;
        end else if (fclk && !fclk_q) begin
            for (int i = 0; i < 4; i++) begin
                w0[i] <= sh[i];
                w1[i] <= sh[4+i];
            end
            flen <= cnt;
            cnt <= 5'h01;
            for (int i = 0; i < 8; i++) begin
                sh[i] <= {13'h0000, pairs[i]};
            end
        end else begin
            cnt <= cnt + 5'h01;
            for (int i = 0; i < 8; i++) begin
                sh[i] <= {sh[i][12:0], pairs[i]};
            end
        end
    end
endmodule : qls_rx_model
`default_nettype wire

// ===== tb/tb_quad_adc_lvds_serializer.sv
// Self-checking bench of the quad converter serializer.
`timescale 1ns/100ps
`default_nettype none
module tb_quad_adc_lvds_serializer;
    import qls_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    qls_sample_t [3:0] samp;
    logic two_w, s14, sdr, lsb, fmt, dphase, cx2;
    qls_order_t ord;
    qls_pattern_t pat;
    logic [11:0] cust;
    logic [1:0] csel;
    logic [4:0] tclk, tdat;
    wire [7:0] pairs;
    wire fclk, bclk, cdbl;
    wire [1:0] ccode;
    wire [4:0] lclk, ldat;
    wire [3:0][13:0] w0, w1;
    wire [4:0] flen;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [11:0] c = 12'h5A3;
    qls_pattern_t pat_tbl [6] = '{QLS_PAT_ZEROS, QLS_PAT_ONES, QLS_PAT_DESKEW, QLS_PAT_DESKEW,
                                  QLS_PAT_CUSTOM, QLS_PAT_SYNC};
    logic [11:0] pexp [6] = '{12'h000, 12'hFFF, 12'hAAA, 12'h555, 12'h3C5, 12'hFC0};

    always #50 core_clk = ~core_clk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end

    qls_serializer DUT (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
        .sample_in(samp), .two_wire_en(two_w), .ser14_en(s14), .sdr_bit_clk(sdr),
        .bit_order(ord), .lsb_first(lsb), .output_code_format(fmt), .test_pattern(pat),
        .deskew_phase(dphase), .custom_word(cust), .drive_current_select(csel),
        .drive_current_x2(cx2), .term_clk_sel(tclk), .term_data_sel(tdat),
        .chan_a_first_pair(pairs[0]), .chan_b_first_pair(pairs[1]),
        .chan_c_first_pair(pairs[2]), .chan_d_first_pair(pairs[3]),
        .chan_a_second_pair(pairs[4]), .chan_b_second_pair(pairs[5]),
        .chan_c_second_pair(pairs[6]), .chan_d_second_pair(pairs[7]),
        .frame_clock_out(fclk), .serial_bit_clock_out(bclk), .drive_current_code(ccode),
        .drive_current_double(cdbl), .term_clk_legs(lclk), .term_data_legs(ldat));
    qls_rx_model u_rx (.link_clk(link_clk), .rst_n(rst_n), .fclk(fclk), .pairs(pairs),
        .w0(w0), .w1(w1), .flen(flen));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [13:0] rev(input logic [13:0] v, input int n);
        logic [13:0] r;
        r = 14'h0000;
        for (int k = 0; k < n; k++) begin
            r[k] = v[n-1-k];
        end
        return r;
    endfunction : rev

    // A bit held for two slots is captured twice by the slot-rate model.
    function automatic logic [13:0] dbl(input logic [5:0] v);
        logic [13:0] r;
        r = 14'h0000;
        for (int k = 0; k < 6; k++) begin
            r[2*k+1 -: 2] = {2{v[k]}};
        end
        return r;
    endfunction : dbl

    task automatic put(input logic p, input logic n, input logic [11:0] v);
        for (int i = 0; i < 4; i++) begin
            samp[i] = '{p, n, v};
        end
    endtask : put

    // The wait covers the conversion delay, the hand-off and several whole frames.
    task automatic expect_all(input logic [13:0] e0, input logic [13:0] e1, input logic [4:0] fl);
        logic b;
        @(negedge link_clk);
        b = bclk;
        @(negedge link_clk);
        check({13'h0000, bclk}, {13'h0000, ~b});
        repeat (60) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            check(w0[i], e0);
            check(w1[i], e1);
        end
        check({9'h000, flen}, {9'h000, fl});
    endtask : expect_all

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        put(1'b0, 1'b0, c);
        {two_w, s14, sdr, lsb, fmt, dphase, cx2} = 7'h00;
        ord = QLS_ORD_BYTE;
        pat = QLS_PAT_NORMAL;
        cust = 12'h3C5;
        {csel, tclk, tdat} = 12'h000;
        repeat (4) @(negedge core_clk);
        check({1'h0, cdbl, ccode, lclk, ldat}, 14'h0000);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            samp[i].code = c + 12'(i);
        end
        repeat (60) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            check(w0[i], {2'h0, c + 12'(i)});
        end
        put(1'b0, 1'b0, c);
        lsb = 1'b1;
        expect_all(rev({2'h0, c}, 12), 14'h0000, 5'h0C);
        lsb = 1'b0;
        fmt = 1'b1;
        expect_all({2'h0, c ^ 12'h800}, 14'h0000, 5'h0C);
        put(1'b1, 1'b0, c);
        expect_all(14'h0FFF, 14'h0000, 5'h0C);
        fmt = 1'b0;
        expect_all(14'h07FF, 14'h0000, 5'h0C);
        put(1'b0, 1'b1, c);
        expect_all(14'h0800, 14'h0000, 5'h0C);
        fmt = 1'b1;
        expect_all(14'h0000, 14'h0000, 5'h0C);
        fmt = 1'b0;
        put(1'b0, 1'b0, c);
        s14 = 1'b1;
        expect_all({2'h0, c}, 14'h0000, 5'h0E);
        s14 = 1'b0;
        for (int k = 0; k < 6; k++) begin
            pat = pat_tbl[k];
            dphase = (k == 3);
            expect_all({2'h0, pexp[k]}, 14'h0000, 5'h0C);
        end
        pat = QLS_PAT_TOGGLE;
        repeat (60) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            check(w0[i], (w0[0] == 14'h0555) ? 14'h0555 : 14'h0AAA);
            check(w1[i], 14'h0000);
        end
        check({9'h000, flen}, {9'h000, 5'h0C});
        pat = QLS_PAT_NORMAL;
        two_w = 1'b1;
        expect_all({8'h00, c[5:0]}, {8'h00, c[11:6]}, 5'h06);
        lsb = 1'b1;
        expect_all(rev({8'h00, c[5:0]}, 6), rev({8'h00, c[11:6]}, 6), 5'h06);
        lsb = 1'b0;
        ord = QLS_ORD_BIT;
        expect_all({8'h00, c[10], c[8], c[6], c[4], c[2], c[0]},
                   {8'h00, c[11], c[9], c[7], c[5], c[3], c[1]}, 5'h06);
        ord = QLS_ORD_WORD;
        expect_all({2'h0, c}, {2'h0, c}, 5'h0C);
        ord = QLS_ORD_BYTE;
        pat = QLS_PAT_CUSTOM;
        expect_all({8'h00, cust[5:0]}, {8'h00, cust[11:6]}, 5'h06);
        pat = QLS_PAT_SYNC;
        expect_all(14'h0038, 14'h0038, 5'h06);
        pat = QLS_PAT_NORMAL;
        sdr = 1'b1;
        expect_all(dbl(c[5:0]), dbl(c[11:6]), 5'h0C);
        sdr = 1'b0;
        s14 = 1'b1;
        expect_all({c[6:0], c[6:0]}, {2'h0, c[11:7], 2'h0, c[11:7]}, 5'h0E);
        for (int k = 0; k < 4; k++) begin
            {csel, cx2, tclk, tdat} = {2'(k), k[0], 5'h15 ^ 5'(k), 5'h0A};
            repeat (3) @(negedge core_clk);
            check({1'h0, cdbl, ccode, lclk, ldat}, {1'h0, k[0], 2'(k), 5'h15 ^ 5'(k), 5'h0A});
        end
        end_of_test();
    end
endmodule : tb_quad_adc_lvds_serializer
`default_nettype wire
